// ===== rtl/limiter_threshold_params.svh
// constants for the limiter threshold decode: offsets, fields, resets, scale
`ifndef LIMITER_THRESHOLD_PARAMS_SVH
`define LIMITER_THRESHOLD_PARAMS_SVH

// byte offsets of the fine threshold registers
`define LTD_OFS_L1_FINE_ATTACK 8'h32
`define LTD_OFS_L1_FINE_RELEASE 8'h33
`define LTD_OFS_L2_FINE_ATTACK 8'h34
`define LTD_OFS_L2_FINE_RELEASE 8'h35

// reset value of every fine threshold register (select off, field zero)
`define LTD_FINE_RESET 8'h00

// fields inside a fine threshold register
`define LTD_FINE_SELECT_BIT 7
`define LTD_FINE_FIELD_MSB 6

// fields inside a 4-bit code pair: attack high nibble, release low nibble
`define LTD_ATTACK_CODE_MSB 7
`define LTD_ATTACK_CODE_LSB 4
`define LTD_RELEASE_CODE_MSB 3
`define LTD_RELEASE_CODE_LSB 0

// levels are carried in eighths of a dB
`define LTD_EIGHTHS_SHIFT 3
// fine base of -12 dB expressed in eighths
`define LTD_FINE_BASE_EIGHTHS 10'sh060
// a fine field count is a quarter dB, i.e. two eighths
`define LTD_FINE_STEP_SHIFT 1

// smallest level width that holds -38 dB and +19.75 dB in eighths
`define LTD_MIN_LEVEL_WIDTH 10

`endif

// ===== rtl/limiter_threshold_pkg.sv
// types shared by the limiter threshold decode files
`default_nettype none
package limiter_threshold_pkg;
  // how a limiter reads its 4-bit threshold codes
  typedef enum logic {
    CLIP_GUARD_MODE,
    COMPRESSION_MODE
  } level_mode_e;
endpackage : limiter_threshold_pkg
`default_nettype wire

// ===== rtl/limiter_level_decode.sv
// per-limiter threshold decode: code tables, fine override, mode forcing
`default_nettype none
`include "limiter_threshold_params.svh"
module limiter_level_decode #(
  parameter int LEVEL_WIDTH = 10
) (
  input wire logic [3:0] attackLevelCode,
  input wire logic [3:0] releaseLevelCode,
  input wire logic compressionModeSelect,
  input wire logic [7:0] fineAttackReg,
  input wire logic [7:0] fineReleaseReg,
  output logic signed [LEVEL_WIDTH-1:0] attackLevel,
  output logic signed [LEVEL_WIDTH-1:0] releaseLevel,
  output logic releaseOff,
  output logic clipGuardMode
);

  // refuse a level width that cannot hold the whole span
  if (LEVEL_WIDTH < `LTD_MIN_LEVEL_WIDTH) begin : g_width_check
    $error("limiter_level_decode: LEVEL_WIDTH too small");
  end

  // clip guard attack: 2 dB steps from -12, then 1 dB steps from +3
  function automatic logic signed [6:0] clipAttackDb(input logic [3:0] c);
    logic signed [6:0] v;
    v = $signed({3'h0, c});
    if (!c[3]) begin
      clipAttackDb = 7'(v + v - 7'sd12);
    end else begin
      clipAttackDb = 7'(v - 7'sd5);
    end
  endfunction : clipAttackDb

  // clip guard release, relative to full scale; code 0 is handled apart
  function automatic logic signed [6:0] clipReleaseDb(input logic [3:0] c);
    case (c)
      4'h1: clipReleaseDb = -7'sd29;
      4'h2: clipReleaseDb = -7'sd20;
      4'h3: clipReleaseDb = -7'sd16;
      4'h4: clipReleaseDb = -7'sd14;
      4'h5: clipReleaseDb = -7'sd12;
      4'h6: clipReleaseDb = -7'sd10;
      4'h7: clipReleaseDb = -7'sd8;
      default: clipReleaseDb = 7'($signed({3'h0, c}) - 7'sd15);
    endcase
  endfunction : clipReleaseDb

  // compression attack, relative to the volume setting
  function automatic logic signed [6:0] compAttackDb(input logic [3:0] c);
    logic signed [6:0] v;
    v = $signed({3'h0, c});
    case (c)
      4'hD: compAttackDb = -7'sd10;
      4'hE: compAttackDb = -7'sd7;
      4'hF: compAttackDb = -7'sd4;
      default: begin
        if (!c[3]) begin
          compAttackDb = 7'(v + v - 7'sd31);
        end else begin
          compAttackDb = 7'(v - 7'sd24);
        end
      end
    endcase
  endfunction : compAttackDb

  // compression release, relative to volume plus attack level
  function automatic logic signed [6:0] compReleaseDb(input logic [3:0] c);
    case (c)
      4'h1: compReleaseDb = -7'sd38;
      4'h2: compReleaseDb = -7'sd36;
      4'h3: compReleaseDb = -7'sd33;
      4'h4: compReleaseDb = -7'sd31;
      4'h5: compReleaseDb = -7'sd30;
      4'h6: compReleaseDb = -7'sd28;
      4'h7: compReleaseDb = -7'sd26;
      4'h8: compReleaseDb = -7'sd24;
      4'h9: compReleaseDb = -7'sd22;
      4'hA: compReleaseDb = -7'sd20;
      4'hB: compReleaseDb = -7'sd18;
      4'hC: compReleaseDb = -7'sd15;
      4'hD: compReleaseDb = -7'sd12;
      4'hE: compReleaseDb = -7'sd9;
      default: compReleaseDb = -7'sd6;
    endcase
  endfunction : compReleaseDb

  // whole dB to eighths at the output width
  function automatic logic signed [LEVEL_WIDTH-1:0] toEighths(
    input logic signed [6:0] db
  );
    toEighths = LEVEL_WIDTH'(db) <<< `LTD_EIGHTHS_SHIFT;
  endfunction : toEighths

  // fine field: -12 dB plus a quarter dB per count, in eighths
  function automatic logic signed [LEVEL_WIDTH-1:0] fineEighths(
    input logic [6:0] f
  );
    logic signed [LEVEL_WIDTH-1:0] s;
    s = $signed(LEVEL_WIDTH'({f, 1'h0}));
    fineEighths = LEVEL_WIDTH'(s - `LTD_FINE_BASE_EIGHTHS);
  endfunction : fineEighths

  // select bits and fields of the two fine registers
  wire logic fineAttackSel = fineAttackReg[`LTD_FINE_SELECT_BIT];
  wire logic fineReleaseSel = fineReleaseReg[`LTD_FINE_SELECT_BIT];
  wire logic [6:0] fineAttackField = fineAttackReg[`LTD_FINE_FIELD_MSB:0];
  wire logic [6:0] fineReleaseField = fineReleaseReg[`LTD_FINE_FIELD_MSB:0];

  // any fine select pulls this limiter into clip guard mode
  wire limiter_threshold_pkg::level_mode_e effMode =
    (fineAttackSel || fineReleaseSel) ?
    limiter_threshold_pkg::CLIP_GUARD_MODE :
    (compressionModeSelect ?
     limiter_threshold_pkg::COMPRESSION_MODE :
     limiter_threshold_pkg::CLIP_GUARD_MODE);

  wire logic isComp = (effMode == limiter_threshold_pkg::COMPRESSION_MODE);

  // coarse levels from the 4-bit codes under the effective mode
  wire logic signed [LEVEL_WIDTH-1:0] coarseAttack = isComp ?
    toEighths(compAttackDb(attackLevelCode)) :
    toEighths(clipAttackDb(attackLevelCode));
  wire logic signed [LEVEL_WIDTH-1:0] coarseRelease = isComp ?
    toEighths(compReleaseDb(releaseLevelCode)) :
    toEighths(clipReleaseDb(releaseLevelCode));

  // minus infinity only exists for the coarse release code zero
  wire logic coarseOff = (releaseLevelCode == 4'h0);

  // fine field wins over the code while its select bit is set
  assign attackLevel = fineAttackSel ? fineEighths(fineAttackField) :
                       coarseAttack;
  assign releaseLevel = fineReleaseSel ? fineEighths(fineReleaseField) :
                        coarseRelease;
  assign releaseOff = !fineReleaseSel && coarseOff;
  assign clipGuardMode = !isComp;

endmodule : limiter_level_decode
`default_nettype wire

// ===== rtl/limiter_threshold_decode.sv
// top of the limiter threshold decode: fine registers and two decoders
`default_nettype none
`include "limiter_threshold_params.svh"
module limiter_threshold_decode #(
  parameter int LEVEL_WIDTH = 10
) (
  input wire logic core_clk,
  input wire logic arst_n,
  // byte register port from the device's control interface
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  output logic regRdHit,
  // configuration from the rest of the register file
  input wire logic compressionModeSelect,
  input wire logic [7:0] lim1LevelCodes,
  input wire logic [7:0] lim2LevelCodes,
  // decoded limiter 1 levels, eighths of a dB
  output logic signed [LEVEL_WIDTH-1:0] lim1AttackLevel,
  output logic signed [LEVEL_WIDTH-1:0] lim1ReleaseLevel,
  output logic lim1ReleaseOff,
  output logic lim1ClipGuardMode,
  // decoded limiter 2 levels, eighths of a dB
  output logic signed [LEVEL_WIDTH-1:0] lim2AttackLevel,
  output logic signed [LEVEL_WIDTH-1:0] lim2ReleaseLevel,
  output logic lim2ReleaseOff,
  output logic lim2ClipGuardMode
);

  // refuse a level width the decoders cannot fill
  if (LEVEL_WIDTH < `LTD_MIN_LEVEL_WIDTH) begin : g_width_check
    $error("limiter_threshold_decode: LEVEL_WIDTH too small");
  end

  // stored fine threshold registers, select bit in the top position
  logic [7:0] l1FineAttack_r;
  logic [7:0] l1FineRelease_r;
  logic [7:0] l2FineAttack_r;
  logic [7:0] l2FineRelease_r;

  // address decode for the four fine registers
  wire logic hitL1Attack = (regAddr == `LTD_OFS_L1_FINE_ATTACK);
  wire logic hitL1Release = (regAddr == `LTD_OFS_L1_FINE_RELEASE);
  wire logic hitL2Attack = (regAddr == `LTD_OFS_L2_FINE_ATTACK);
  wire logic hitL2Release = (regAddr == `LTD_OFS_L2_FINE_RELEASE);
  wire logic hitAny = hitL1Attack || hitL1Release ||
                      hitL2Attack || hitL2Release;

  // read selection; other addresses belong to neighbours and give zero
  wire logic [7:0] rdSel;
  assign rdSel = hitL1Attack ? l1FineAttack_r :
                 hitL1Release ? l1FineRelease_r :
                 hitL2Attack ? l2FineAttack_r :
                 hitL2Release ? l2FineRelease_r :
                 8'h00;

  // limiter 1 fine attack register, full byte stored
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      l1FineAttack_r <= `LTD_FINE_RESET;
    end else if (regWrEn && hitL1Attack) begin
      l1FineAttack_r <= regWrData;
    end
  end

  // limiter 1 fine release register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      l1FineRelease_r <= `LTD_FINE_RESET;
    end else if (regWrEn && hitL1Release) begin
      l1FineRelease_r <= regWrData;
    end
  end

  // limiter 2 fine attack register, separate from limiter 1
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      l2FineAttack_r <= `LTD_FINE_RESET;
    end else if (regWrEn && hitL2Attack) begin
      l2FineAttack_r <= regWrData;
    end
  end

  // limiter 2 fine release register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      l2FineRelease_r <= `LTD_FINE_RESET;
    end else if (regWrEn && hitL2Release) begin
      l2FineRelease_r <= regWrData;
    end
  end

  // read data is registered: one cycle after the read strobe
  // a simultaneous write shows the old value, the new one on the next read
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= 8'h00;
      regRdHit <= 1'b0;
    end else if (regRdEn) begin
      regRdData <= rdSel;
      regRdHit <= hitAny;
    end else begin
      regRdHit <= 1'b0;
    end
  end

  // combinational decode results of both limiters
  logic signed [LEVEL_WIDTH-1:0] l1AttackNxt;
  logic signed [LEVEL_WIDTH-1:0] l1ReleaseNxt;
  logic l1OffNxt;
  logic l1ClipNxt;
  logic signed [LEVEL_WIDTH-1:0] l2AttackNxt;
  logic signed [LEVEL_WIDTH-1:0] l2ReleaseNxt;
  logic l2OffNxt;
  logic l2ClipNxt;

  // limiter 1 decoder
  limiter_level_decode #(
    .LEVEL_WIDTH(LEVEL_WIDTH)
  ) u_lim1 (
    .attackLevelCode(
      lim1LevelCodes[`LTD_ATTACK_CODE_MSB:`LTD_ATTACK_CODE_LSB]),
    .releaseLevelCode(
      lim1LevelCodes[`LTD_RELEASE_CODE_MSB:`LTD_RELEASE_CODE_LSB]),
    .compressionModeSelect(compressionModeSelect),
    .fineAttackReg(l1FineAttack_r),
    .fineReleaseReg(l1FineRelease_r),
    .attackLevel(l1AttackNxt),
    .releaseLevel(l1ReleaseNxt),
    .releaseOff(l1OffNxt),
    .clipGuardMode(l1ClipNxt)
  );

  // limiter 2 decoder, fed from its own fine registers
  limiter_level_decode #(
    .LEVEL_WIDTH(LEVEL_WIDTH)
  ) u_lim2 (
    .attackLevelCode(
      lim2LevelCodes[`LTD_ATTACK_CODE_MSB:`LTD_ATTACK_CODE_LSB]),
    .releaseLevelCode(
      lim2LevelCodes[`LTD_RELEASE_CODE_MSB:`LTD_RELEASE_CODE_LSB]),
    .compressionModeSelect(compressionModeSelect),
    .fineAttackReg(l2FineAttack_r),
    .fineReleaseReg(l2FineRelease_r),
    .attackLevel(l2AttackNxt),
    .releaseLevel(l2ReleaseNxt),
    .releaseOff(l2OffNxt),
    .clipGuardMode(l2ClipNxt)
  );

  // output stage: all levels registered so the limiter core sees clean
  // values; costs one cycle of latency, harmless for slow configuration
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lim1AttackLevel <= '0;
      lim1ReleaseLevel <= '0;
      lim1ReleaseOff <= 1'b0;
      lim1ClipGuardMode <= 1'b1;
    end else begin
      lim1AttackLevel <= l1AttackNxt;
      lim1ReleaseLevel <= l1ReleaseNxt;
      lim1ReleaseOff <= l1OffNxt;
      lim1ClipGuardMode <= l1ClipNxt;
    end
  end

  // limiter 2 output stage
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lim2AttackLevel <= '0;
      lim2ReleaseLevel <= '0;
      lim2ReleaseOff <= 1'b0;
      lim2ClipGuardMode <= 1'b1;
    end else begin
      lim2AttackLevel <= l2AttackNxt;
      lim2ReleaseLevel <= l2ReleaseNxt;
      lim2ReleaseOff <= l2OffNxt;
      lim2ClipGuardMode <= l2ClipNxt;
    end
  end

endmodule : limiter_threshold_decode
`default_nettype wire

// ===== tb/limiter_threshold_assertions.sv
// checker watching the limiter threshold decode ports
`default_nettype none
module limiter_threshold_checker #(
  parameter int LEVEL_WIDTH = 10
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic regRdHit,
  input wire logic compressionModeSelect,
  input wire logic [7:0] lim1LevelCodes,
  input wire logic [7:0] lim2LevelCodes,
  input wire logic signed [LEVEL_WIDTH-1:0] lim1AttackLevel,
  input wire logic signed [LEVEL_WIDTH-1:0] lim1ReleaseLevel,
  input wire logic lim1ReleaseOff,
  input wire logic lim1ClipGuardMode,
  input wire logic signed [LEVEL_WIDTH-1:0] lim2AttackLevel,
  input wire logic signed [LEVEL_WIDTH-1:0] lim2ReleaseLevel,
  input wire logic lim2ReleaseOff,
  input wire logic lim2ClipGuardMode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // address falls on one of the four fine registers
  wire logic regMapped = regAddr >= 8'h32 && regAddr <= 8'h35;
  // select bits mirrored from writes, indexed by the low address bits
  logic [3:0] fineSel_r;
  // mirror only; it assumes writes land, which a_fine_attack and a_fine_release back up for 8'h32 and 8'h35
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) fineSel_r <= 4'h0;
    else if (regWrEn && regMapped) fineSel_r[regAddr[1:0]] <= regWrData[7];
  end
  a_read_hit: assert property (regRdEn && regMapped |=> regRdHit)
    else $error("mapped read gave no hit");
  a_read_miss: assert property (regRdEn && !regMapped |=>
    !regRdHit && regRdData == 8'h00) else $error("unmapped read answered");
  a_fine_attack: assert property (regWrEn && regAddr == 8'h32 &&
    regWrData[7] ##1 !(regWrEn && regAddr == 8'h32) |=>
    lim1AttackLevel == 2 * int'($past(regWrData[6:0], 2)) - 96)
    else $error("fine attack level wrong");
  a_fine_release: assert property (regWrEn && regAddr == 8'h35 &&
    regWrData[7] ##1 !(regWrEn && regAddr == 8'h35) |=> !lim2ReleaseOff &&
    lim2ReleaseLevel == 2 * int'($past(regWrData[6:0], 2)) - 96)
    else $error("fine release level wrong");
  a_mode_force: assert property (fineSel_r[2] || fineSel_r[3]
    |=> lim1ClipGuardMode) else $error("fine select did not force mode");
  // the sampled reset gates the next three: at the releasing edge the
  // disable has already lifted while the outputs still hold reset values
  a_comp_mode: assert property (arst_n &&
    compressionModeSelect && fineSel_r[1:0] == 2'b00 |=> !lim2ClipGuardMode)
    else $error("compression mode not taken");
  a_release_off: assert property (arst_n &&
    lim1LevelCodes[3:0] == 4'h0 && !fineSel_r[3] |=> lim1ReleaseOff)
    else $error("release not off");
  a_clip_top: assert property (arst_n && !compressionModeSelect &&
    !fineSel_r[2] && lim1LevelCodes[7:4] == 4'hF |=> lim1AttackLevel == 80)
    else $error("top clip attack level wrong");
endmodule : limiter_threshold_checker
bind limiter_threshold_decode limiter_threshold_checker #(
  .LEVEL_WIDTH(LEVEL_WIDTH)) chk (.core_clk, .arst_n, .regAddr, .regWrData,
  .regWrEn, .regRdEn, .regRdData, .regRdHit, .compressionModeSelect,
  .lim1LevelCodes, .lim2LevelCodes, .lim1AttackLevel, .lim1ReleaseLevel,
  .lim1ReleaseOff, .lim1ClipGuardMode, .lim2AttackLevel, .lim2ReleaseLevel,
  .lim2ReleaseOff, .lim2ClipGuardMode);
`default_nettype wire

// ===== tb/limiter_threshold_decode_bench.sv
// self-checking bench for the limiter threshold decode
`default_nettype none
module limiter_threshold_decode_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
  logic regWrEn = 1'b0, regRdEn = 1'b0, compressionModeSelect = 1'b0;
  logic [7:0] lim1LevelCodes = 8'h00, lim2LevelCodes = 8'h00;
  logic regRdHit, lim1ReleaseOff, lim1ClipGuardMode;
  logic lim2ReleaseOff, lim2ClipGuardMode;
  logic signed [9:0] lim1AttackLevel, lim1ReleaseLevel;
  logic signed [9:0] lim2AttackLevel, lim2ReleaseLevel;
  int errors = 0;
  int checked = 0;
  // level tables in whole dB; release entry 0 stands for off
  int acA[16] = '{-12, -10, -8, -6, -4, -2, 0, 2, 3, 4, 5, 6, 7, 8, 9, 10};
  int acR[16] = '{0, -29, -20, -16, -14, -12, -10, -8, -7, -6, -5, -4, -3,
    -2, -1, 0};
  int drA[16] = '{-31, -29, -27, -25, -23, -21, -19, -17, -16, -15, -14,
    -13, -12, -10, -7, -4};
  int drR[16] = '{0, -38, -36, -33, -31, -30, -28, -26, -24, -22, -20, -18,
    -15, -12, -9, -6};
  int fv[3] = '{0, 48, 127};
  limiter_threshold_decode DUT (.core_clk, .arst_n, .regAddr, .regWrData,
    .regWrEn, .regRdEn, .regRdData, .regRdHit, .compressionModeSelect,
    .lim1LevelCodes, .lim2LevelCodes, .lim1AttackLevel, .lim1ReleaseLevel,
    .lim1ReleaseOff, .lim1ClipGuardMode, .lim2AttackLevel,
    .lim2ReleaseLevel, .lim2ReleaseOff, .lim2ClipGuardMode);
  // free running 50 MHz clock
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // verdict in one place
  task automatic end_of_test();
    if (errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  // case equality so an unknown never matches
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // let registered outputs follow a change made at the last edge
  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask : settle
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask : wr
  // one-cycle read strobe, answer looked at in the following cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic h);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1;
    chk(10'(regRdData), 10'(d));
    chk(10'(regRdHit), 10'(h));
  endtask : rd
  // coarse levels in eighths; release level is ignored while off
  task automatic coarse(input logic signed [9:0] att, rel, input logic off,
      clip, input int m, a, r);
    chk(att, 10'((m ? drA[a] : acA[a]) * 8));
    chk(10'(off), 10'(r == 0));
    if (r != 0) chk(rel, 10'((m ? drR[r] : acR[r]) * 8));
    chk(10'(clip), 10'(m == 0));
  endtask : coarse
  // hang guard
  initial begin
    repeat (5000) @(posedge core_clk);
    errors++;
    $display("unexpected at %0t: run too long", $time);
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 4; i++) rd(8'h32 + 8'(i), 8'h00, 1'b1);
    rd(8'h31, 8'h00, 1'b0);
    // every code in both modes, limiter 2 given the reversed attack code
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 16; c++) begin
        @(posedge core_clk);
        compressionModeSelect <= m[0];
        lim1LevelCodes <= {c[3:0], c[3:0]};
        lim2LevelCodes <= {~c[3:0], c[3:0]};
        settle();
        coarse(lim1AttackLevel, lim1ReleaseLevel, lim1ReleaseOff,
          lim1ClipGuardMode, m, c, c);
        coarse(lim2AttackLevel, lim2ReleaseLevel, lim2ReleaseOff,
          lim2ClipGuardMode, m, 15 - c, c);
      end
    end
    // fine fields at both ends, in compression mode with release off codes
    @(posedge core_clk);
    lim1LevelCodes <= 8'h00;
    lim2LevelCodes <= 8'h00;
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 4; i++) begin
        wr(8'h32 + 8'(i), {1'b1, 7'(fv[k] ^ i)});
      end
      settle();
      chk(lim1AttackLevel, 10'(2 * fv[k] - 96));
      chk(lim1ReleaseLevel, 10'(2 * (fv[k] ^ 1) - 96));
      chk(lim2AttackLevel, 10'(2 * (fv[k] ^ 2) - 96));
      chk(lim2ReleaseLevel, 10'(2 * (fv[k] ^ 3) - 96));
      chk({lim1ReleaseOff, lim2ReleaseOff, lim1ClipGuardMode,
        lim2ClipGuardMode}, 10'h003);
      for (int i = 0; i < 4; i++)
        rd(8'h32 + 8'(i), {1'b1, 7'(fv[k] ^ i)}, 1'b1);
    end
    // release select off: coarse code but still forced to clip guard
    wr(8'h33, 8'h7F);
    wr(8'h34, 8'h00);
    wr(8'h35, 8'h00);
    // unmapped write must not alias onto a fine register
    wr(8'h36, 8'h80);
    @(posedge core_clk);
    lim1LevelCodes <= 8'h09;
    lim2LevelCodes <= 8'hF1;
    settle();
    chk(lim1ReleaseLevel, 10'(-48));
    chk(10'(lim1ClipGuardMode), 10'h001);
    coarse(lim2AttackLevel, lim2ReleaseLevel, lim2ReleaseOff,
      lim2ClipGuardMode, 1, 15, 1);
    rd(8'h33, 8'h7F, 1'b1);
    rd(8'h32, 8'hFF, 1'b1);
    rd(8'h36, 8'h00, 1'b0);
    // mid-run reset clears the fine registers and frees the mode again
    @(posedge core_clk);
    arst_n <= 1'b0;
    @(posedge core_clk);
    arst_n <= 1'b1;
    rd(8'h33, 8'h00, 1'b1);
    coarse(lim1AttackLevel, lim1ReleaseLevel, lim1ReleaseOff,
      lim1ClipGuardMode, 1, 0, 9);
    end_of_test();
  end
endmodule : limiter_threshold_decode_bench
`default_nettype wire
